// file: gpc_defs.svh
// register offsets, field widths and reset values of the gpio port
`ifndef GPC_DEFS_SVH
`define GPC_DEFS_SVH
`define GPC_OFF_FUNC 12'h000
`define GPC_OFF_DRIVE 12'h004
`define GPC_OFF_PULL 12'h00C
`define GPC_OFF_IN 12'h010
`define GPC_OFF_OUT 12'h014
`define GPC_OFF_SETCLR 12'h018
`define GPC_OFF_ALT_LO 12'h020
`define GPC_OFF_ALT_HI 12'h024
`define GPC_OFF_XCTL 12'h040
`define GPC_FUNC_W 2
`define GPC_PULL_W 2
`define GPC_ALT_W 3
`define GPC_ALT_NUM 8
`define GPC_HALF 16
`define GPC_ALT_STRIDE 4
`define GPC_FUNC_RESET 32'hFFFF_FFFF
`define GPC_PULL_RESET 32'h0000_0000
`define GPC_ZERO 32'h0000_0000
`endif

// file: gpc_pkg.sv
// types shared by the gpio port
package gpc_pkg;
  typedef enum logic [1:0] {
    GPC_FN_INPUT = 2'b00,
    GPC_FN_OUTPUT = 2'b01,
    GPC_FN_ALT = 2'b10,
    GPC_FN_ANALOG = 2'b11
  } gpc_func_e;
  typedef enum logic [1:0] {
    GPC_PULL_NONE = 2'b00,
    GPC_PULL_UP = 2'b01,
    GPC_PULL_DOWN = 2'b10,
    GPC_PULL_RSVD = 2'b11
  } gpc_pull_e;
endpackage : gpc_pkg

// file: gpc_port.sv
// gpio port: pin control registers, apb slave and per-pin output logic
// How it works
// - two-bit field picks input/output/alternate/analog
// - drive type bit: push-pull or open-drain
// - pull applies in every digital mode except other-unit digital takeover
// - pull 11 written keeps previous setting
// - analog: no drive, no pull, input 0
// - reset: all analog except two pins
// - debug clock pulldown, data pullup, boot pulldown for one cycle after reset
// - alternate mux resets to function zero
// - one of eight sources per pin
// - three-bit select, low and high registers
// - other-unit functions override pin configuration; drive type bit still applies to digital takeover
// - fast crystal: both analog, bypass input only
// - slow crystal enable makes both pins analog
// - set strobe sets, clear strobe clears
// - clear bits 31:16, set 15:0, read zero
// - zero strobes leave output unchanged
// - set wins over clear
// - set/clear in one write access
// - output data read/write, input read-only
// - input mode samples pin, pulls apply
// - open-drain never drives high
// - push-pull drives data value
// - output mode reads pin level back
`include "gpc_defs.svh"
module gpc_port import gpc_pkg::*; #(
  parameter int NPINS = 16,
  parameter int BOOT_PIN = 9,
  parameter int DBG_DATA_PIN = 13,
  parameter int DBG_CLK_PIN = 14,
  parameter int FXTAL_IN_PIN = 0,
  parameter int FXTAL_OUT_PIN = 1,
  parameter int SXTAL_IN_PIN = 14,
  parameter int SXTAL_OUT_PIN = 15
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NPINS-1:0] pin_in,
  output logic [NPINS-1:0] pin_out,
  output logic [NPINS-1:0] pin_oe,
  output logic [NPINS-1:0] pin_pull_up,
  output logic [NPINS-1:0] pin_pull_down,
  output logic [NPINS-1:0] pin_analog,
  input wire logic [NPINS*`GPC_ALT_NUM-1:0] alt_out,
  input wire logic [NPINS*`GPC_ALT_NUM-1:0] alt_oe,
  output logic [NPINS-1:0] alt_in,
  input wire logic [NPINS-1:0] ext_analog_req,
  input wire logic [NPINS-1:0] ext_dig_en,
  input wire logic [NPINS-1:0] ext_dig_out,
  input wire logic [NPINS-1:0] ext_dig_oe
);
  ////////////////////////////////////////////////////////////////////
  // registers
  logic [2*NPINS-1:0] pin_function_select, next_pin_function_select;
  logic [NPINS-1:0] output_drive_type, next_output_drive_type;
  logic [2*NPINS-1:0] pull_resistor_select, next_pull_resistor_select;
  logic [NPINS-1:0] pin_output_value, next_pin_output_value;
  logic [3*NPINS-1:0] alt_sel, next_alt_sel;
  logic [2:0] xtal_ctl, next_xtal_ctl;
  logic [NPINS-1:0] pin_meta, pin_sync, pin_input_sample, next_pin_input_sample;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic wr, rd;
  logic [31:0] wmask;
  logic [2*NPINS-1:0] func_rst, pull_rst, pull_wr;
  logic [NPINS-1:0] set_strobe, clear_strobe;
  logic [NPINS-1:0] in_reset;
  logic fast_crystal_enable, fast_crystal_bypass, slow_crystal_enable;

  assign fast_crystal_enable = xtal_ctl[0];
  assign fast_crystal_bypass = xtal_ctl[1];
  assign slow_crystal_enable = xtal_ctl[2];
  assign wr = psel && penable && pwrite && pready;
  assign rd = psel && !penable;
  assign set_strobe = pwdata[NPINS-1:0];
  assign clear_strobe = pwdata[`GPC_HALF+NPINS-1:`GPC_HALF];

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[8*b +: 8] = {8{pstrb[b]}};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // reset values
  always_comb begin
    func_rst = `GPC_FUNC_RESET;
    pull_rst = `GPC_PULL_RESET;
    func_rst[2*DBG_DATA_PIN +: 2] = GPC_FN_ALT;
    func_rst[2*DBG_CLK_PIN +: 2] = GPC_FN_ALT;
    pull_rst[2*DBG_DATA_PIN +: 2] = GPC_PULL_UP;
    pull_rst[2*DBG_CLK_PIN +: 2] = GPC_PULL_DOWN;
  end

  always_comb begin
    pull_wr = pull_resistor_select;
    for (int i = 0; i < NPINS; i++) begin
      if (pwdata[2*i +: 2] != GPC_PULL_RSVD) begin
        pull_wr[2*i +: 2] = pwdata[2*i +: 2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // register writes
  always_comb begin
    next_pin_function_select = pin_function_select;
    next_output_drive_type = output_drive_type;
    next_pull_resistor_select = pull_resistor_select;
    next_pin_output_value = pin_output_value;
    next_alt_sel = alt_sel;
    next_xtal_ctl = xtal_ctl;
    if (wr) begin
      unique case (paddr)
        `GPC_OFF_FUNC: next_pin_function_select =
          (pin_function_select & ~wmask[2*NPINS-1:0]) | (pwdata[2*NPINS-1:0] & wmask[2*NPINS-1:0]);
        `GPC_OFF_DRIVE: next_output_drive_type =
          (output_drive_type & ~wmask[NPINS-1:0]) | (pwdata[NPINS-1:0] & wmask[NPINS-1:0]);
        `GPC_OFF_PULL: next_pull_resistor_select =
          (pull_resistor_select & ~wmask[2*NPINS-1:0]) | (pull_wr & wmask[2*NPINS-1:0]);
        `GPC_OFF_OUT: next_pin_output_value =
          (pin_output_value & ~wmask[NPINS-1:0]) | (pwdata[NPINS-1:0] & wmask[NPINS-1:0]);
        `GPC_OFF_SETCLR: next_pin_output_value =
          (pin_output_value & ~clear_strobe) | set_strobe;
        `GPC_OFF_ALT_LO, `GPC_OFF_ALT_HI: begin
          for (int i = 0; i < NPINS; i++) begin
            if ((i / 8 == ((paddr == `GPC_OFF_ALT_HI) ? 1 : 0)) && pstrb[(i % 8) / 2]) begin
              next_alt_sel[3*i +: 3] = pwdata[`GPC_ALT_STRIDE*(i % 8) +: `GPC_ALT_W];
            end
          end
        end
        `GPC_OFF_XCTL: if (pstrb[0]) next_xtal_ctl = pwdata[2:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_function_select <= func_rst;
      output_drive_type <= '0;
      pull_resistor_select <= pull_rst;
      pin_output_value <= '0;
      alt_sel <= '0;
      xtal_ctl <= '0;
    end else begin
      pin_function_select <= next_pin_function_select;
      output_drive_type <= next_output_drive_type;
      pull_resistor_select <= next_pull_resistor_select;
      pin_output_value <= next_pin_output_value;
      alt_sel <= next_alt_sel;
      xtal_ctl <= next_xtal_ctl;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // apb read and answer
  always_comb begin
    next_prdata = `GPC_ZERO;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    if (rd) begin
      next_pready = 1'b1;
      unique case (paddr)
        `GPC_OFF_FUNC: next_prdata[2*NPINS-1:0] = pin_function_select;
        `GPC_OFF_DRIVE: next_prdata[NPINS-1:0] = output_drive_type;
        `GPC_OFF_PULL: next_prdata[2*NPINS-1:0] = pull_resistor_select;
        `GPC_OFF_IN: next_prdata[NPINS-1:0] = pin_input_sample;
        `GPC_OFF_OUT: next_prdata[NPINS-1:0] = pin_output_value;
        `GPC_OFF_SETCLR: next_prdata = `GPC_ZERO;
        `GPC_OFF_ALT_LO, `GPC_OFF_ALT_HI: begin
          for (int i = 0; i < NPINS; i++) begin
            if (i / 8 == ((paddr == `GPC_OFF_ALT_HI) ? 1 : 0)) begin
              next_prdata[`GPC_ALT_STRIDE*(i % 8) +: `GPC_ALT_W] = alt_sel[3*i +: 3];
            end
          end
        end
        `GPC_OFF_XCTL: next_prdata[2:0] = xtal_ctl;
        default: next_pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= `GPC_ZERO;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // input synchroniser
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_meta <= '0;
      pin_sync <= '0;
      pin_input_sample <= '0;
      in_reset <= '1;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
      pin_input_sample <= next_pin_input_sample;
      in_reset <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // per-pin pad control
  logic [NPINS-1:0] next_pin_out, next_pin_oe, next_pu, next_pd, next_an, next_alt_in;
  genvar g;
  generate
    for (g = 0; g < NPINS; g++) begin : g_pin
      logic forced_an, an, od, dval, den;
      logic o_out, o_oe, o_pu, o_pd, o_in, o_ai;
      gpc_func_e fn;
      gpc_pull_e pl;
      logic [2:0] s;
      assign fn = gpc_func_e'(pin_function_select[2*g +: 2]);
      assign pl = gpc_pull_e'(pull_resistor_select[2*g +: 2]);
      assign s = alt_sel[3*g +: 3];
      assign forced_an = ext_analog_req[g]
        || (fast_crystal_enable && g == FXTAL_IN_PIN)
        || (fast_crystal_enable && !fast_crystal_bypass && g == FXTAL_OUT_PIN)
        || (slow_crystal_enable && (g == SXTAL_IN_PIN || g == SXTAL_OUT_PIN));
      assign an = forced_an || (!ext_dig_en[g] && fn == GPC_FN_ANALOG);
      assign od = output_drive_type[g];
      always_comb begin
        dval = 1'b0;
        den = 1'b0;
        if (ext_dig_en[g]) begin
          dval = ext_dig_out[g];
          den = ext_dig_oe[g];
        end else if (fn == GPC_FN_OUTPUT) begin
          dval = pin_output_value[g];
          den = 1'b1;
        end else if (fn == GPC_FN_ALT) begin
          dval = alt_out[`GPC_ALT_NUM*g + s];
          den = alt_oe[`GPC_ALT_NUM*g + s];
        end
        o_out = 1'b0;
        o_oe = 1'b0;
        if (!an && den) begin
          o_out = od ? 1'b0 : dval;
          o_oe = od ? !dval : 1'b1;
        end
        o_pu = !an && !ext_dig_en[g] && pl == GPC_PULL_UP;
        o_pd = !an && !ext_dig_en[g] && pl == GPC_PULL_DOWN;
        o_in = an ? 1'b0 : pin_sync[g];
        o_ai = (!an && fn == GPC_FN_ALT) ? pin_sync[g] : 1'b0;
      end
      assign next_pin_out[g] = o_out;
      assign next_pin_oe[g] = o_oe;
      assign next_pu[g] = o_pu;
      assign next_pd[g] = o_pd;
      assign next_an[g] = an;
      assign next_pin_input_sample[g] = o_in;
      assign next_alt_in[g] = o_ai;
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_out <= '0;
      pin_oe <= '0;
      pin_pull_up <= '0;
      pin_pull_down <= '0;
      pin_analog <= '1;
      alt_in <= '0;
    end else begin
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
      pin_pull_up <= next_pu;
      pin_pull_down <= next_pd | (in_reset & (NPINS'(1) << BOOT_PIN));
      pin_analog <= next_an;
      alt_in <= next_alt_in;
    end
  end
endmodule : gpc_port

// file: gpc_port_chk.sv
// assertions on the gpio port pins and apb answers
module gpc_port_chk #(
  parameter int NPINS = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic [NPINS-1:0] pin_oe,
  input wire logic [NPINS-1:0] pin_pull_up,
  input wire logic [NPINS-1:0] pin_pull_down,
  input wire logic [NPINS-1:0] pin_analog,
  input wire logic [NPINS-1:0] ext_analog_req,
  input wire logic [NPINS-1:0] ext_dig_en,
  input wire logic [NPINS-1:0] ext_dig_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_setclr_reads_zero: assert property (
    psel && !penable && !pwrite && paddr == 12'h018 |=> prdata == 32'h0000_0000)
    else $error("set/clear read not zero");
  a_reset_all_analog: assert property (disable iff (1'b0)
    rst |=> pin_analog == '1 && pin_oe == '0 && !pready)
    else $error("reset state wrong");
  a_analog_no_drive: assert property (
    !$past(rst) && !$past(rst, 2) |-> ((pin_oe | pin_pull_up) & pin_analog) == '0)
    else $error("analog pin driven or pulled");
  a_pull_exclusive: assert property ((pin_pull_up & pin_pull_down) == '0)
    else $error("both pulls on");
  a_ext_analog_wins: assert property (
    ext_analog_req == '1 [*2] |=> pin_analog == '1 && pin_pull_down == '0)
    else $error("analog request ignored");
  a_ext_dig_takes: assert property (
    (ext_dig_en == '1 && ext_analog_req == '0) [*2]
    |=> pin_oe == $past(ext_dig_oe) && pin_pull_up == '0)
    else $error("digital takeover ignored");
endmodule : gpc_port_chk
bind gpc_port gpc_port_chk #(.NPINS(NPINS)) u_gpc_port_chk (.clk, .rst, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pin_oe, .pin_pull_up, .pin_pull_down, .pin_analog,
  .ext_analog_req, .ext_dig_en, .ext_dig_oe);

// file: gpc_pad_model.sv
// pad model: resolves each pin from port drive, pulls and an outside driver
module gpc_pad_model (
  input wire logic clk,
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe,
  input wire logic [15:0] pin_pull_up,
  input wire logic [15:0] pin_pull_down,
  input wire logic [15:0] pad_drive,
  input wire logic [15:0] pad_float,
  output logic [15:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] wobble = 16'h5A5A;
  always_ff @(posedge clk) begin
    wobble <= ~wobble;
  end
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (!pad_float[i]) pin_in[i] = pad_drive[i];
      else if (pin_pull_up[i]) pin_in[i] = 1'b1;
      else if (pin_pull_down[i]) pin_in[i] = 1'b0;
      else pin_in[i] = wobble[i];
    end
  end
endmodule : gpc_pad_model

// file: tb_top.sv
// testbench for the gpio port: apb register tests and pin checks
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] pstrb;
  logic [15:0] pin_in, pin_out, pin_oe, pin_pull_up, pin_pull_down, pin_analog, alt_in;
  logic [15:0] ext_analog_req, ext_dig_en, ext_dig_out, ext_dig_oe, pad_drive, pad_float;
  logic [127:0] alt_out, alt_oe, altv;
  int failures, cmp_count;
  gpc_port u_gpc_port (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .pin_in, .pin_out, .pin_oe, .pin_pull_up, .pin_pull_down, .pin_analog,
    .alt_out, .alt_oe, .alt_in, .ext_analog_req, .ext_dig_en, .ext_dig_out, .ext_dig_oe);
  gpc_pad_model u_gpc_pad_model (.clk, .pin_out, .pin_oe, .pin_pull_up, .pin_pull_down,
    .pad_drive, .pad_float, .pin_in);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      $display("mismatch at %0t: no pready", $time);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, exp);
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    repeat (2) @(posedge clk);
  endtask : wr
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    give_verdict();
  end
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata, pstrb} = {3'b100, 45'h0, 4'hF};
    {alt_out, alt_oe, altv} = '0;
    {ext_analog_req, ext_dig_en, ext_dig_out, ext_dig_oe, pad_drive} = '0;
    pad_float = 16'hFFFF;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk({30'h0, pin_pull_up[13], pin_pull_down[14]}, 32'h0000_0003);
    rd(12'h000, 32'hEBFF_FFFF);
    rd(12'h00C, 32'h2400_0000);
    rd(12'h020, 32'h0000_0000);
    rd(12'h024, 32'h0000_0000);
    wr(12'h00C, 32'h0000_0001);
    wr(12'h00C, 32'h0000_0003);
    rd(12'h00C, 32'h0000_0001);
    wr(12'h000, 32'h5555_5555);
    wr(12'h014, 32'h0000_A5A5);
    chk({pin_oe, pin_out}, 32'hFFFF_A5A5);
    chk({31'h0, pin_pull_up[0]}, 32'h0000_0001);
    repeat (6) @(posedge clk);
    rd(12'h010, 32'h0000_A5A5);
    wr(12'h010, 32'h0000_0000);
    rd(12'h014, 32'h0000_A5A5);
    wr(12'h018, 32'h0F0F_0F00);
    rd(12'h014, 32'h0000_AFA0);
    rd(12'h018, 32'h0000_0000);
    wr(12'h004, 32'h0000_FFFF);
    chk({pin_oe, pin_out & pin_oe}, 32'h505F_0000);
    wr(12'h004, 32'h0000_0000);
    wr(12'h00C, 32'h0000_0009);
    wr(12'h000, 32'h0000_0000);
    pad_float <= 16'h0003;
    pad_drive <= 16'h3C5A;
    repeat (6) @(posedge clk);
    rd(12'h010, 32'h0000_3C59);
    wr(12'h000, 32'hFFFF_FFFF);
    repeat (6) @(posedge clk);
    rd(12'h010, 32'h0000_0000);
    chk({pin_analog, pin_pull_up}, 32'hFFFF_0000);
    wr(12'h020, 32'h7654_3210);
    wr(12'h024, 32'h0123_4567);
    rd(12'h024, 32'h0123_4567);
    for (int p = 0; p < 16; p++) altv[8 * p + (p < 8 ? p : 15 - p)] = 1'b1;
    alt_out <= altv;
    alt_oe <= '1;
    wr(12'h000, 32'hAAAA_AAAA);
    chk({pin_oe, pin_out}, 32'hFFFF_FFFF);
    repeat (3) @(posedge clk);
    chk({16'h0, alt_in}, 32'h0000_FFFF);
    alt_out <= ~altv;
    repeat (3) @(posedge clk);
    chk({pin_oe, pin_out}, 32'hFFFF_0000);
    wr(12'h000, 32'h5555_5555);
    wr(12'h040, 32'h0000_0001);
    chk({16'h0, pin_analog}, 32'h0000_0003);
    wr(12'h040, 32'h0000_0003);
    chk({16'h0, pin_analog}, 32'h0000_0001);
    wr(12'h040, 32'h0000_0004);
    chk({16'h0, pin_analog}, 32'h0000_C000);
    wr(12'h040, 32'h0000_0000);
    ext_dig_oe <= 16'h00FF;
    ext_dig_out <= 16'h0F0F;
    ext_dig_en <= '1;
    repeat (3) @(posedge clk);
    chk({pin_oe, pin_out & pin_oe}, 32'h00FF_000F);
    ext_dig_en <= '0;
    ext_analog_req <= '1;
    repeat (3) @(posedge clk);
    chk({pin_analog, pin_oe}, 32'hFFFF_0000);
    ext_analog_req <= '0;
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    chk({31'h0, e}, 32'h0000_0001);
    give_verdict();
  end
endmodule : tb_top
